// ---- design/bba_unit.sv ----
// Bit-run BCD add, subtract and multiply accumulator datapath
`timescale 1ns/1ps
`default_nettype none
module bba_unit
   import bba_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              start_i,
   input  wire bba_op_t           op_i,
   input  wire logic [ADDR_W-1:0] bit_addr_i,
   input  wire logic [5:0]        bit_count_i,
   input  wire logic              acc_load_i,
   input  wire logic [31:0]       acc_load_data_i,
   output logic                   bit_rd_en_o,
   output logic [ADDR_W-1:0]      bit_rd_addr_o,
   input  wire logic              bit_rd_data_i,
   output logic                   busy_o,
   output logic                   done_o,
   output logic                   cmd_err_o,
   output logic [31:0]            acc_o,
   output bba_flags_t             flags_o
);
   // ==========================================================
   // State
   typedef struct packed {
      bba_st_t          st;
      bba_op_t          op;
      logic [ADDR_W-1:0] addr;
      logic [5:0]       cnt;
      logic [5:0]       idx;
      logic [31:0]      opnd;
      logic [31:0]      acc;
      logic [31:0]      prod;
      logic [1:0]       dig;
      logic [3:0]       rep;
      logic             err;
      bba_flags_t       flg;
   } bba_state_t;

   bba_state_t s_q;
   bba_state_t s_d;

   logic        len_ok;
   logic [33:0] add_w;
   logic [33:0] sub_w;
   logic [33:0] mac_w;

   // ==========================================================
   // Arithmetic
   assign add_w = bcd_add(s_q.acc, s_q.opnd, 1'b0);
   assign sub_w = bcd_add(s_q.acc, bcd_nines(s_q.opnd), 1'b1);
   assign mac_w = bcd_add(s_q.prod, {16'h0000, s_q.acc[15:0]}, 1'b0);

   always_comb begin
      if (op_i == BBA_MUL) begin
         len_ok = (bit_count_i >= LEN_MIN) && (bit_count_i <= LEN_MAX_MU);
      end else begin
         len_ok = (bit_count_i >= LEN_MIN) && (bit_count_i <= LEN_MAX_AS)
                  && (op_i != 2'h3);
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      s_d     = s_q;
      s_d.err = 1'b0;
      unique case (s_q.st)
         ST_IDLE: begin
            if (start_i) begin
               if (len_ok) begin
                  s_d.st   = ST_REQ;
                  s_d.op   = op_i;
                  s_d.addr = bit_addr_i;
                  s_d.cnt  = bit_count_i;
                  s_d.idx  = '0;
                  s_d.opnd = '0;
               end else begin
                  s_d.err = 1'b1;
               end
            end else if (acc_load_i) begin
               s_d.acc = acc_load_data_i;
            end
         end
         ST_REQ: begin
            s_d.st = ST_CAP;
         end
         ST_CAP: begin
            // lowest address is LSB, rest stays zero
            s_d.opnd[s_q.idx[4:0]] = bit_rd_data_i;
            s_d.idx  = s_q.idx + 6'h01;
            s_d.addr = s_q.addr + 16'h0001;
            s_d.st   = (s_q.idx + 6'h01 == s_q.cnt) ? ST_CALC : ST_REQ;
         end
         ST_CALC: begin
            s_d.flg.invalid_bcd_flag = bcd_bad(s_q.opnd) |
               ((s_q.op == BBA_MUL) ? bcd_bad({16'h0000, s_q.acc[15:0]}) : bcd_bad(s_q.acc));
            s_d.st = ST_DONE;
            unique case (s_q.op)
               BBA_ADD: begin
                  s_d.acc = add_w[31:0];
                  s_d.flg.carry16_flag = add_w[32];
                  s_d.flg.carry32_flag = add_w[33];
                  s_d.flg.negative_result_flag = 1'b0;
               end
               BBA_SUB: begin
                  s_d.acc = sub_w[31:0];
                  s_d.flg.borrow16_flag = ~sub_w[32];
                  s_d.flg.borrow32_flag = ~sub_w[33];
                  s_d.flg.negative_result_flag = ~sub_w[33];
               end
               default: begin
                  s_d.st   = ST_MUL;
                  s_d.prod = '0;
                  s_d.dig  = MUL_TOP;
                  s_d.rep  = s_q.opnd[15:12];
               end
            endcase
         end
         ST_MUL: begin
            if (s_q.rep != 4'h0) begin
               s_d.prod = mac_w[31:0];
               s_d.rep  = s_q.rep - 4'h1;
            end else if (s_q.dig == 2'h0) begin
               s_d.acc = s_q.prod;
               s_d.flg.negative_result_flag = 1'b0;
               s_d.st  = ST_DONE;
            end else begin
               s_d.dig  = s_q.dig - 2'h1;
               s_d.prod = {s_q.prod[27:0], 4'h0};
               s_d.rep  = s_q.opnd[4*(s_q.dig - 2'h1) +: 4];
            end
         end
         ST_DONE: begin
            s_d.st = ST_IDLE;
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
      // zero flag rewritten only by a finishing operation
      if (s_d.st == ST_DONE && s_q.st != ST_DONE) begin
         s_d.flg.zero_result_flag = (s_d.acc == 32'h0000_0000);
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q     <= '0;
         s_q.st  <= ST_IDLE;
         s_q.acc <= ACC_RST;
         s_q.flg <= FLAGS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs
   assign bit_rd_en_o   = (s_q.st == ST_REQ);
   assign bit_rd_addr_o = s_q.addr;
   assign busy_o        = (s_q.st != ST_IDLE);
   assign done_o        = (s_q.st == ST_DONE);
   assign cmd_err_o     = s_q.err;
   assign acc_o         = s_q.acc;
   assign flags_o       = s_q.flg;

   // ==========================================================
   // Checks
   sequence s_start_ok;
      start_i && !busy_o && len_ok;
   endsequence

   sequence s_finish;
      ##[3:120] done_o;
   endsequence

   a_start_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_start_ok |-> s_finish) else $error("Legal operation did not finish");

   a_mul_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      start_i && !busy_o && op_i == BBA_MUL && bit_count_i > LEN_MAX_MU
      |=> cmd_err_o && !busy_o) else $error("Over-long multiply accepted");

   a_add_sum: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_q.st == ST_CALC && s_q.op == BBA_ADD |=> acc_o == $past(add_w[31:0])
      && flags_o.carry16_flag == $past(add_w[32])
      && flags_o.carry32_flag == $past(add_w[33])
      && (flags_o.invalid_bcd_flag || !bcd_bad(acc_o))) else $error("Add result wrong");

   a_sub_diff: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_q.st == ST_CALC && s_q.op == BBA_SUB |=> acc_o == $past(sub_w[31:0])
      && flags_o.borrow16_flag == !$past(sub_w[32])
      && flags_o.borrow32_flag == !$past(sub_w[33])
      && (flags_o.invalid_bcd_flag || !bcd_bad(acc_o))) else $error("Subtract result wrong");

   a_zero_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done_o |-> flags_o.zero_result_flag == (acc_o == 32'h0000_0000))
      else $error("Zero flag wrong");

   a_neg_sub: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done_o && s_q.op != BBA_SUB |-> !flags_o.negative_result_flag)
      else $error("Negative flag on add or multiply");

   a_add_borrow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      busy_o && s_q.op == BBA_ADD |=> $stable(flags_o.borrow16_flag)
      && $stable(flags_o.borrow32_flag)) else $error("Add changed a borrow flag");

   a_mul_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      busy_o && s_q.op == BBA_MUL |=> $stable(flags_o.carry16_flag)
      && $stable(flags_o.borrow16_flag) && $stable(flags_o.carry32_flag))
      else $error("Multiply changed carry or borrow");

   a_idle_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !busy_o |=> $stable(flags_o)) else $error("Flags changed while idle");
endmodule
`default_nettype wire

// ---- design/bba_pkg.sv ----
// Constants, types and helpers for the bit-run BCD arithmetic unit
package bba_pkg;
   localparam int          ADDR_W     = 16;
   localparam logic [5:0]  LEN_MIN    = 6'h01;
   localparam logic [5:0]  LEN_MAX_AS = 6'h20;
   localparam logic [5:0]  LEN_MAX_MU = 6'h10;
   localparam logic [31:0] ACC_RST    = 32'h0000_0000;
   localparam logic [1:0]  MUL_TOP    = 2'h3;

   typedef enum logic [1:0] {
      BBA_ADD = 2'h0,
      BBA_SUB = 2'h1,
      BBA_MUL = 2'h2
   } bba_op_t;

   // Gray codes along idle-fetch-calc-multiply-done
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_REQ  = 3'h1,
      ST_CAP  = 3'h3,
      ST_CALC = 3'h2,
      ST_MUL  = 3'h6,
      ST_DONE = 3'h7
   } bba_st_t;

   typedef struct packed {
      logic zero_result_flag;
      logic carry16_flag;
      logic carry32_flag;
      logic borrow16_flag;
      logic borrow32_flag;
      logic negative_result_flag;
      logic invalid_bcd_flag;
   } bba_flags_t;

   localparam bba_flags_t FLAGS_RST = '0;

   // 8-digit BCD add, returns {carry32, carry16, sum}
   function automatic logic [33:0] bcd_add(input logic [31:0] a, input logic [31:0] b,
                                           input logic cin);
      logic [4:0]  s;
      logic        c;
      logic        c16;
      logic [31:0] r;
      c   = cin;
      c16 = 1'b0;
      r   = '0;
      for (int i = 0; i < 8; i++) begin
         s = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, c};
         c = (s > 5'h09);
         if (c) begin
            s = s + 5'h06;
         end
         r[4*i +: 4] = s[3:0];
         if (i == 3) begin
            c16 = c;
         end
      end
      return {c, c16, r};
   endfunction

   // Nines complement of 8 BCD digits
   function automatic logic [31:0] bcd_nines(input logic [31:0] a);
      logic [31:0] r;
      for (int i = 0; i < 8; i++) begin
         r[4*i +: 4] = 4'h9 - a[4*i +: 4];
      end
      return r;
   endfunction

   // True when any digit is above nine
   function automatic logic bcd_bad(input logic [31:0] a);
      logic b;
      b = 1'b0;
      for (int i = 0; i < 8; i++) begin
         b = b | (a[4*i +: 4] > 4'h9);
      end
      return b;
   endfunction
endpackage

// ---- test/bba_unit_tb.sv ----
// Self-checking bench for the bit-run BCD arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module bcd_bitfield_arith_unit_tb
   import bba_pkg::*;
;
   // =========================================================
   // Stimulus and observed signals
   logic              clk_i           = 1'b0;
   logic              rst_n_i         = 1'b0;
   logic              start_i         = 1'b0;
   bba_op_t           op_i            = BBA_ADD;
   logic [ADDR_W-1:0] bit_addr_i      = 16'h0040;
   logic [5:0]        bit_count_i     = 6'h01;
   logic              acc_load_i      = 1'b0;
   logic [31:0]       acc_load_data_i = 32'h0000_0000;
   logic              bit_rd_data_i   = 1'b0;
   logic              bit_rd_en_o;
   logic [ADDR_W-1:0] bit_rd_addr_o;
   logic              busy_o;
   logic              done_o;
   logic              cmd_err_o;
   logic [31:0]       acc_o;
   bba_flags_t        flags_o;
   logic              mem [0:255];
   logic [7:0]        rd_a            = 8'h00;
   int                err_count       = 0;
   int                checks_done     = 0;
   int                cyc             = 0;
   logic [1:0]        bad_op [0:6]    = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
   logic [5:0]        bad_n  [0:6]    = '{6'h00, 6'h21, 6'h00, 6'h21, 6'h11, 6'h00, 6'h04};

   bba_unit bba_unit_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i),
      .bit_addr_i(bit_addr_i), .bit_count_i(bit_count_i), .acc_load_i(acc_load_i),
      .acc_load_data_i(acc_load_data_i), .bit_rd_en_o(bit_rd_en_o),
      .bit_rd_addr_o(bit_rd_addr_o), .bit_rd_data_i(bit_rd_data_i), .busy_o(busy_o),
      .done_o(done_o), .cmd_err_o(cmd_err_o), .acc_o(acc_o), .flags_o(flags_o));

   // =========================================================
   // Clock, bit image answer one cycle after a read strobe
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (bit_rd_en_o === 1'b1) begin
         rd_a <= bit_rd_addr_o[7:0];
      end
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   always @(negedge clk_i) begin
      bit_rd_data_i = mem[rd_a];
   end

   // =========================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask

   task automatic load(input logic [31:0] v);
      @(negedge clk_i);
      acc_load_i      = 1'b1;
      acc_load_data_i = v;
      @(negedge clk_i);
      acc_load_i      = 1'b0;
      chk("acc_load", v, acc_o);
   endtask

   // Bit run at the start address holds all 32 bits of v; only n of them may count
   task automatic run(input bba_op_t op, input logic [31:0] v, input logic [5:0] n,
                      input logic ca, input logic [31:0] ea, input logic [6:0] ef,
                      input logic [6:0] fm);
      int w;
      for (int k = 0; k < 32; k++) begin
         mem[bit_addr_i[7:0] + k] = v[k];
      end
      @(negedge clk_i);
      start_i     = 1'b1;
      op_i        = op;
      bit_count_i = n;
      @(negedge clk_i);
      start_i = 1'b0;
      w = 0;
      while (done_o !== 1'b1 && w < 2000) begin
         @(negedge clk_i);
         w++;
      end
      chk("done", 32'h1, {31'h0, done_o});
      if (op != BBA_MUL) chk("latency", 32'(2 * n + 1), 32'(w));
      if (ca) chk("acc", ea, acc_o);
      chk("flags", {25'h0, ef & fm}, {25'h0, flags_o & fm});
   endtask

   task automatic refuse(input logic [1:0] op, input logic [5:0] n);
      @(negedge clk_i);
      start_i     = 1'b1;
      op_i        = bba_op_t'(op);
      bit_count_i = n;
      @(negedge clk_i);
      start_i = 1'b0;
      chk("cmd_err", 32'h1, {31'h0, cmd_err_o});
      chk("busy", 32'h0, {31'h0, busy_o});
      chk("acc_kept", 32'h0000_0042, acc_o);
   endtask

   task automatic results();
      $display("checks_done %0d err_count %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // =========================================================
   // Test sequence
   initial begin
      for (int k = 0; k < 256; k++) begin
         mem[k] = 1'b0;
      end
      repeat (8) @(negedge clk_i);
      rst_n_i = 1'b1;
      load(32'h0000_9999);
      run(BBA_ADD, 32'hFFFF_0001, 6'h10, 1'b1, 32'h0001_0000, 7'h20, 7'h7F);
      run(BBA_ADD, 32'h0000_0035, 6'h04, 1'b1, 32'h0001_0005, 7'h00, 7'h7F);
      $display("test add done");
      load(32'h9999_9999);
      run(BBA_ADD, 32'hFFFF_FFFF, 6'h01, 1'b1, 32'h0000_0000, 7'h70, 7'h7F);
      run(BBA_SUB, 32'h0000_0001, 6'h20, 1'b1, 32'h9999_9999, 7'h3E, 7'h7F);
      run(BBA_SUB, 32'h0000_9999, 6'h10, 1'b1, 32'h9999_0000, 7'h30, 7'h7F);
      $display("test subtract done");
      run(BBA_MUL, 32'hFFFF_0003, 6'h10, 1'b1, 32'h0000_0000, 7'h70, 7'h7F);
      bit_addr_i = 16'h0093;
      load(32'h0000_1234);
      run(BBA_MUL, 32'h0000_FF11, 6'h08, 1'b1, 32'h0001_3574, 7'h00, 7'h43);
      $display("test multiply done");
      run(BBA_ADD, 32'h0000_000A, 6'h04, 1'b0, 32'h0, 7'h01, 7'h01);
      $display("test invalid digit done");
      load(32'h0000_0042);
      for (int i = 0; i < 7; i++) begin
         refuse(bad_op[i], bad_n[i]);
      end
      $display("test refused lengths done");
      results();
   end
endmodule
`default_nettype wire
